// ---- acd_adc_ctrl.sv ----
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module acd_adc_ctrl #(
   parameter int CONV_CLKS = acd_pkg::CONV_CLKS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [11:0] sar_result,
   output logic conv_power_on,
   output logic conv_active,
   output logic conv_clk_tick,
   output logic [2:0] source_select,
   output logic [3:0] ext_channel_select,
   output logic [1:0] reference_select,
   output logic ext_route_on,
   output logic [4:0] pin_analog_mode,
   output logic [4:0] pullup_disable,
   output logic conv_irq_req
);
   typedef struct packed {
      logic start;
      logic busy;
      logic en;
      logic align;
      logic [3:0] chan;
      logic [7:0] ctrl_b;
      logic [7:0] cnt;
      logic [11:0] result;
      logic [11:0] sync1;
      logic [11:0] sync2;
      logic irq;
      logic pready;
      logic pslverr;
      logic [7:0] prdata;
   } acd_st_t;

   acd_st_t st_ff;
   acd_st_t nxt_st;
   acd_link_if lnk ();
   logic acc;
   logic wr;
   logic start_fall;
   logic src_ext;
   logic [4:0] pin_sel;
   logic [7:0] ctrl_a_rd;

   // ==========================================================
   // Helpers
   acd_clk_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .lnk(lnk.div)
   );

   acd_result_fmt u_fmt (
      .pclk(pclk),
      .presetn(presetn),
      .lnk(lnk.fmt)
   );

   assign lnk.div_code = st_ff.ctrl_b[acd_pkg::CB_DIV_LSB +: 3];
   assign lnk.run = st_ff.busy;
   assign lnk.result = st_ff.result;
   assign lnk.align = st_ff.align;

   // ==========================================================
   // Input routing
   always_comb begin
      src_ext = (source_select == acd_pkg::SRC_EXT) || (source_select > acd_pkg::SRC_LINE);
      unique case (st_ff.chan)
         4'h0: pin_sel = 5'h01;
         4'h1: pin_sel = 5'h02;
         4'h3: pin_sel = 5'h04;
         4'h5: pin_sel = 5'h08;
         4'h7: pin_sel = 5'h10;
         default: pin_sel = 5'h00;
      endcase
   end

   // Internal sources never share the node with a pin
   assign pin_analog_mode = src_ext ? pin_sel : 5'h00;
   assign pullup_disable = pin_analog_mode;
   assign ext_route_on = |pin_analog_mode;
   assign source_select = st_ff.ctrl_b[acd_pkg::CB_SRC_LSB +: 3];
   assign reference_select = st_ff.ctrl_b[acd_pkg::CB_REF_LSB +: 2];
   assign ext_channel_select = st_ff.chan;
   assign conv_power_on = st_ff.en;
   assign conv_active = st_ff.busy;
   assign conv_clk_tick = lnk.tick;
   assign conv_irq_req = st_ff.irq;

   // ==========================================================
   // Bus answer, one wait state so read data comes from a flop
   assign prdata = {24'h000000, st_ff.prdata};
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;

   always_comb begin
      ctrl_a_rd = '0;
      ctrl_a_rd[acd_pkg::CA_START_BIT] = st_ff.start;
      ctrl_a_rd[acd_pkg::CA_BUSY_BIT] = st_ff.busy;
      ctrl_a_rd[acd_pkg::CA_EN_BIT] = st_ff.en;
      ctrl_a_rd[acd_pkg::CA_ALIGN_BIT] = st_ff.align;
      ctrl_a_rd[acd_pkg::CA_CHAN_LSB +: 4] = st_ff.chan;
   end

   // ==========================================================
   // Next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.irq = 1'b0;
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;
      acc = psel && penable;
      wr = acc && st_ff.pready && pwrite && !st_ff.pslverr;
      start_fall = wr && (paddr == acd_pkg::OFS_CTRL_A) && st_ff.start
         && !pwdata[acd_pkg::CA_START_BIT];
      // Result is analog-side, so it passes two flops
      nxt_st.sync1 = sar_result;
      nxt_st.sync2 = st_ff.sync1;

      if (acc && !st_ff.pready) begin
         nxt_st.pready = 1'b1;
         unique case (paddr)
            acd_pkg::OFS_RESULT_HI: nxt_st.prdata = lnk.hi_byte;
            acd_pkg::OFS_RESULT_LO: nxt_st.prdata = lnk.lo_byte;
            acd_pkg::OFS_CTRL_A: nxt_st.prdata = ctrl_a_rd;
            acd_pkg::OFS_CTRL_B: nxt_st.prdata = st_ff.ctrl_b;
            default: begin
               nxt_st.prdata = 8'h00;
               nxt_st.pslverr = 1'b1;
            end
         endcase
      end

      // Busy bit is not writable; result registers ignore writes
      if (wr && paddr == acd_pkg::OFS_CTRL_A) begin
         nxt_st.start = pwdata[acd_pkg::CA_START_BIT];
         nxt_st.en = pwdata[acd_pkg::CA_EN_BIT];
         nxt_st.align = pwdata[acd_pkg::CA_ALIGN_BIT];
         nxt_st.chan = pwdata[acd_pkg::CA_CHAN_LSB +: 4];
      end
      if (wr && paddr == acd_pkg::OFS_CTRL_B) begin
         nxt_st.ctrl_b = pwdata[7:0];
      end

      // Gated by enable so a conversion cut by power-down never loads a result
      if (st_ff.busy && st_ff.en && lnk.tick) begin
         if (st_ff.cnt == 8'(CONV_CLKS - 1)) begin
            nxt_st.busy = 1'b0;
            nxt_st.cnt = 8'h00;
            nxt_st.result = st_ff.sync2;
            nxt_st.irq = 1'b1;
         end else begin
            nxt_st.cnt = 8'(st_ff.cnt + 8'h01);
         end
      end
      // A start while busy is ignored rather than restarting
      if (start_fall && st_ff.en && !st_ff.busy) begin
         nxt_st.busy = 1'b1;
         nxt_st.cnt = 8'h00;
      end
      // Power-down aborts; result keeps its last value
      if (!st_ff.en) begin
         nxt_st.busy = 1'b0;
         nxt_st.cnt = 8'h00;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
         st_ff.ctrl_b <= acd_pkg::CTRL_B_RST;
         st_ff.result <= acd_pkg::RESULT_RST;
         {st_ff.start, st_ff.busy, st_ff.en, st_ff.align, st_ff.chan} <= acd_pkg::CTRL_A_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   busy_launch_a: assert property (start_fall && st_ff.en && !st_ff.busy |=> st_ff.busy)
      else $error("start sequence did not set busy");
   busy_cause_a: assert property ($rose(st_ff.busy) |-> $past(start_fall) && $past(st_ff.en))
      else $error("busy rose without start sequence");
   conv_end_a: assert property (st_ff.busy && lnk.tick && st_ff.en && st_ff.cnt == 8'(CONV_CLKS - 1)
      |=> conv_irq_req && !st_ff.busy)
      else $error("conversion end missed");
   load_result_a: assert property (conv_irq_req |-> st_ff.result == $past(st_ff.sync2))
      else $error("result not loaded at completion");
   irq_pulse_a: assert property (conv_irq_req |=> !conv_irq_req)
      else $error("interrupt request longer than one cycle");
   hold_off_a: assert property (!st_ff.en |=> $stable(st_ff.result))
      else $error("result changed while disabled");
   off_abort_a: assert property (!st_ff.en |=> !st_ff.busy)
      else $error("busy while converter disabled");
   float_chan_a: assert property (ext_channel_select[3] |-> pin_analog_mode == 5'h00 && !ext_route_on)
      else $error("nonexistent channel connected a pin");
   chan_map_a: assert property (ext_channel_select == 4'h5 && source_select == acd_pkg::SRC_EXT
      |-> pin_analog_mode == 5'h08 && pullup_disable == 5'h08)
      else $error("channel five mapped wrong");
   internal_src_a: assert property (source_select == acd_pkg::SRC_BANDGAP |-> !ext_route_on)
      else $error("internal source shared with pin");

   conv_done_c: cover property (st_ff.busy ##[1:300] conv_irq_req);
   conv_abort_c: cover property (st_ff.busy ##1 !st_ff.en);
   read_right_c: cover property (pready && !pwrite && paddr == acd_pkg::OFS_RESULT_LO && st_ff.align);
   restart_ign_c: cover property (start_fall && st_ff.busy);
endmodule : acd_adc_ctrl

// ---- acd_pkg.sv ----
// What this block does
// - Twelve-bit result held in two byte registers
// - Align 0: high=D11..D4, low=D3..D0 then zeros
// - Align 1: high=zeros then D11..D8, low=D7..D0
// - Unused result bit positions read zero
// - Disabled converter leaves result registers unchanged
// - Start bit written 1 then 0 launches
// - Busy set on launch; busy is read-only
// - Busy cleared when conversion completes
// - Enable bit powers converter on or off
// - Channel codes 0,1,3,5,7 map; others reserved
// - Channel codes 8 to 15 select nothing
// - Source and channel selects choose one input
// - Selected pin loses digital function and pull-up
// - First control register resets to zero
// - Source codes: external, bandgap, amps, line
// - Clock select divides by 1 to 128
// - Completion raises converter interrupt request
package acd_pkg;
   // ==========================================================
   // Register map, byte addresses
   localparam logic [11:0] OFS_RESULT_HI = 12'h000;
   localparam logic [11:0] OFS_RESULT_LO = 12'h004;
   localparam logic [11:0] OFS_CTRL_A = 12'h008;
   localparam logic [11:0] OFS_CTRL_B = 12'h00C;
   // ==========================================================
   // Control register A fields
   localparam int CA_START_BIT = 7;
   localparam int CA_BUSY_BIT = 6;
   localparam int CA_EN_BIT = 5;
   localparam int CA_ALIGN_BIT = 4;
   localparam int CA_CHAN_LSB = 0;
   // Control register B fields
   localparam int CB_SRC_LSB = 5;
   localparam int CB_REF_LSB = 3;
   localparam int CB_DIV_LSB = 0;
   // ==========================================================
   // Reset values
   localparam logic [7:0] CTRL_A_RST = 8'h00;
   localparam logic [7:0] CTRL_B_RST = 8'h00;
   localparam logic [11:0] RESULT_RST = 12'h000;
   // ==========================================================
   // Source select codes; all others are external
   localparam logic [2:0] SRC_EXT = 3'h0;
   localparam logic [2:0] SRC_BANDGAP = 3'h1;
   localparam logic [2:0] SRC_SENSE0 = 3'h2;
   localparam logic [2:0] SRC_SENSE1 = 3'h3;
   localparam logic [2:0] SRC_LINE = 3'h4;
   // Conversion length in divided clocks
   localparam int CONV_CLKS = 16;
endpackage : acd_pkg

// ---- acd_link_if.sv ----
`timescale 1ns/1ps
interface acd_link_if;
   logic [2:0] div_code;
   logic run;
   logic tick;
   logic [11:0] result;
   logic align;
   logic [7:0] hi_byte;
   logic [7:0] lo_byte;
   modport ctl(output div_code, run, result, align, input tick, hi_byte, lo_byte);
   modport div(input div_code, run, output tick);
   modport fmt(input result, align, output hi_byte, lo_byte);
endinterface : acd_link_if

// ---- acd_clk_div.sv ----
`timescale 1ns/1ps
module acd_clk_div (
   input wire logic pclk,
   input wire logic presetn,
   acd_link_if.div lnk
);
   typedef struct packed {
      logic [6:0] cnt;
   } acd_div_st_t;
   acd_div_st_t st_ff;
   acd_div_st_t nxt_st;
   logic [6:0] lim;

   // ==========================================================
   // Divider; restarts with each conversion so phase is fixed
   always_comb begin
      nxt_st = st_ff;
      lim = 7'((8'h01 << lnk.div_code) - 8'h01);
      lnk.tick = lnk.run && (st_ff.cnt == lim);
      if (!lnk.run || lnk.tick) begin
         nxt_st.cnt = 7'h00;
      end else begin
         nxt_st.cnt = 7'(st_ff.cnt + 7'h01);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // Checks
   div_two_a: assert property (@(posedge pclk) disable iff (!presetn)
      lnk.tick && lnk.div_code == 3'h1 ##1 $stable(lnk.div_code) && lnk.run |-> !lnk.tick)
      else $error("divide by two ticked twice in a row");
   div_one_a: assert property (@(posedge pclk) disable iff (!presetn)
      lnk.run && lnk.div_code == 3'h0 |-> lnk.tick)
      else $error("divide by one missed a tick");
endmodule : acd_clk_div

// ---- acd_result_fmt.sv ----
`timescale 1ns/1ps
module acd_result_fmt (
   input wire logic pclk,
   input wire logic presetn,
   acd_link_if.fmt lnk
);
   // ==========================================================
   // Alignment of the stored result into two bytes
   always_comb begin
      if (lnk.align) begin
         lnk.hi_byte = {4'h0, lnk.result[11:8]};
         lnk.lo_byte = lnk.result[7:0];
      end else begin
         lnk.hi_byte = lnk.result[11:4];
         lnk.lo_byte = {lnk.result[3:0], 4'h0};
      end
   end

   // ==========================================================
   // Checks
   align_left_a: assert property (@(posedge pclk) disable iff (!presetn)
      !lnk.align |-> {lnk.hi_byte, lnk.lo_byte} == {lnk.result, 4'h0})
      else $error("left aligned result wrong");
   align_right_a: assert property (@(posedge pclk) disable iff (!presetn)
      lnk.align |-> {lnk.hi_byte, lnk.lo_byte} == {4'h0, lnk.result})
      else $error("right aligned result wrong");
endmodule : acd_result_fmt

// ---- acd_adc_ctrl_tb.sv ----
`timescale 1ns/1ps
module acd_adc_ctrl_tb;
   // ==========================================================
   // Signals
   localparam int NCONV = 2;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [11:0] sar_result = 12'hABC;
   logic [31:0] prdata;
   logic pready, pslverr, conv_power_on, conv_active, conv_clk_tick, ext_route_on, conv_irq_req;
   logic [2:0] source_select;
   logic [3:0] ext_channel_select;
   logic [1:0] reference_select;
   logic [4:0] pin_analog_mode, pullup_disable;
   logic [31:0] rd;
   logic err;
   int errors = 0;
   int comparisons = 0;
   int ticks = 0;
   int irqs = 0;
   int gap = 0;
   int last = 0;
   int cyc = 0;

   acd_adc_ctrl #(.CONV_CLKS(NCONV)) i_acd_adc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sar_result(sar_result), .conv_power_on(conv_power_on), .conv_active(conv_active),
      .conv_clk_tick(conv_clk_tick), .source_select(source_select), .ext_channel_select(ext_channel_select),
      .reference_select(reference_select), .ext_route_on(ext_route_on), .pin_analog_mode(pin_analog_mode),
      .pullup_disable(pullup_disable), .conv_irq_req(conv_irq_req));

   initial begin
      forever #4 pclk = ~pclk;
   end

   // ==========================================================
   // Tick spacing and completion pulses
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (conv_clk_tick === 1'b1) begin
         ticks <= ticks + 1;
         gap <= cyc - last;
         last <= cyc;
      end
      if (conv_irq_req === 1'b1) begin
         irqs <= irqs + 1;
      end
   end

   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : conclude

   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         errors++;
         conclude();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let the write's effects land before any port check
      #1;
   endtask : apb

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rd, exp);
   endtask : rdchk

   task automatic wait_done();
      int n;
      for (n = 0; n < 3000; n++) begin
         @(posedge pclk);
         if (conv_active !== 1'b1) break;
      end
      if (n == 3000) begin
         errors++;
         conclude();
      end
   endtask : wait_done

   function automatic logic [4:0] pin_of(input int c);
      case (c)
         0: pin_of = 5'h01;
         1: pin_of = 5'h02;
         3: pin_of = 5'h04;
         5: pin_of = 5'h08;
         7: pin_of = 5'h10;
         default: pin_of = 5'h00;
      endcase
   endfunction : pin_of

   // ==========================================================
   // Main sequence
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rdchk(acd_pkg::OFS_CTRL_A, 32'h0);
      rdchk(acd_pkg::OFS_CTRL_B, 32'h0);
      chk(conv_active, 32'h0);
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, acd_pkg::OFS_CTRL_A, 8'h20 | 8'(c));
         chk(ext_channel_select, 32'(c));
         chk(pin_analog_mode, pin_of(c));
         chk(pullup_disable, pin_of(c));
         chk(ext_route_on, pin_of(c) != 5'h00);
      end
      // Real channel selected so internal sources must cut the pin
      apb(1'b1, acd_pkg::OFS_CTRL_A, 8'h23);
      for (int s = 0; s < 8; s++) begin
         apb(1'b1, acd_pkg::OFS_CTRL_B, {3'(s), 2'(s), 3'h3});
         chk(source_select, 32'(s));
         chk(ext_route_on, (s == 0) || (s > 4));
         chk(pin_analog_mode, ((s == 0) || (s > 4)) ? 5'h04 : 5'h00);
         chk(reference_select, 32'(s & 3));
         rdchk(acd_pkg::OFS_CTRL_B, {24'h0, 3'(s), 2'(s), 3'h3});
      end
      // Divide by 8, external source, channel 0
      apb(1'b1, acd_pkg::OFS_CTRL_B, 8'h03);
      apb(1'b1, acd_pkg::OFS_CTRL_A, 8'hA0);
      chk(conv_active, 32'h0);
      apb(1'b1, acd_pkg::OFS_CTRL_A, 8'h20);
      rdchk(acd_pkg::OFS_CTRL_A, 32'h60);
      wait_done();
      rdchk(acd_pkg::OFS_CTRL_A, 32'h20);
      rdchk(acd_pkg::OFS_RESULT_HI, 32'hAB);
      rdchk(acd_pkg::OFS_RESULT_LO, 32'hC0);
      chk(irqs, 32'h1);
      chk(ticks, NCONV);
      chk(gap, 32'h8);
      apb(1'b1, acd_pkg::OFS_CTRL_A, 8'h30);
      rdchk(acd_pkg::OFS_RESULT_HI, 32'h0A);
      rdchk(acd_pkg::OFS_RESULT_LO, 32'hBC);
      apb(1'b1, acd_pkg::OFS_CTRL_A, 8'h70);
      rdchk(acd_pkg::OFS_CTRL_A, 32'h30);
      apb(1'b1, acd_pkg::OFS_RESULT_HI, 8'hFF);
      rdchk(acd_pkg::OFS_RESULT_HI, 32'h0A);
      rdchk(12'h010, 32'h0);
      chk(err, 32'h1);
      // Abort mid-conversion by clearing enable
      sar_result <= 12'h123;
      apb(1'b1, acd_pkg::OFS_CTRL_A, 8'hA0);
      apb(1'b1, acd_pkg::OFS_CTRL_A, 8'h20);
      apb(1'b1, acd_pkg::OFS_CTRL_A, 8'h00);
      @(posedge pclk);
      #1;
      chk(conv_active, 32'h0);
      chk(conv_power_on, 32'h0);
      rdchk(acd_pkg::OFS_RESULT_HI, 32'hAB);
      rdchk(acd_pkg::OFS_RESULT_LO, 32'hC0);
      apb(1'b1, acd_pkg::OFS_CTRL_A, 8'h80);
      apb(1'b1, acd_pkg::OFS_CTRL_A, 8'h00);
      repeat (4) @(posedge pclk);
      chk(conv_active, 32'h0);
      chk(irqs, 32'h1);
      // Fast conversion clocks: divide by two, then by one
      for (int d = 1; d >= 0; d--) begin
         apb(1'b1, acd_pkg::OFS_CTRL_B, 8'(d));
         apb(1'b1, acd_pkg::OFS_CTRL_A, 8'hB0);
         apb(1'b1, acd_pkg::OFS_CTRL_A, 8'h30);
         wait_done();
         chk(gap, 32'(1 << d));
         rdchk(acd_pkg::OFS_RESULT_LO, 32'h23);
         rdchk(acd_pkg::OFS_RESULT_HI, 32'h01);
      end
      chk(irqs, 32'h3);
      conclude();
   end
endmodule : acd_adc_ctrl_tb
